// [logic/drs_status_bank.sv]
// read-only status register bank answering register load queries
`timescale 1ns/1ps
`default_nettype none
module drs_status_bank import drs_pkg::*; #(
	parameter bit          BIPOLAR    = 1'b1, // bipolar analog command
	parameter bit          REL_AT_END = 1'b0, // relative distance at end
	parameter int unsigned IO_LAYOUT  = 1,    // input word layout 0..3
	parameter int unsigned END_LEN    = END_CYCLES
) (
	input  wire logic        mclk,              // 40 MHz clock
	input  wire logic        sys_rst,           // async reset, high
	input  wire logic        ce,                // clock enable
	input  wire logic        query_valid,       // register upload request
	input  wire logic  [7:0] query_index,       // register number
	input  wire logic        load_valid,        // load attempt
	input  wire logic  [7:0] load_index,        // load target number
	output logic             answer_valid,      // answer pulse
	output logic             answer_known,      // index was mapped
	output logic      [31:0] answer_data,       // answer value
	output logic             load_ack,          // load taken, no error
	input  wire logic [15:0] analog_cmd_raw,    // signed converter value
	input  wire logic [15:0] analog_offset_command, // signed offset
	input  wire logic  [5:0] program_line,      // executing line
	input  wire logic [15:0] current_command,   // 0.01 A units
	input  wire logic [31:0] fault_in,          // fault bits
	input  wire logic  [7:0] control_mode,      // mode number
	input  wire logic  [3:0] run_phase,         // point-to-point state
	input  wire logic        traj_step,         // trajectory step
	input  wire logic        traj_dir,          // 1 counts down
	input  wire logic        enc_step,          // encoder count
	input  wire logic        enc_dir,           // 1 counts down
	input  wire logic        encoder_preset_command, // preset strobe
	input  wire logic [31:0] encoder_preset_value,   // preset value
	input  wire logic        set_position,      // position preset
	input  wire logic [31:0] set_position_value, // preset value
	input  wire logic        rel_move_start,    // relative move begins
	input  wire logic        rel_move_done,     // relative move ends
	input  wire logic        sensor_move_active, // sensor-type move
	input  wire logic        sensor_pin,        // sensor input pin
	input  wire logic        test_exec,         // test or compare runs
	input  wire logic [31:0] test_first,        // first operand signed
	input  wire logic [31:0] test_second,       // second operand signed
	input  wire logic  [7:0] inputs_closed_pin, // isolated inputs closed
	input  wire logic        index_closed_pin,  // encoder index
	input  wire logic        step_closed_pin,   // step input
	input  wire logic        dir_closed_pin,    // direction input
	input  wire logic        en_closed_pin,     // enable input
	input  wire logic  [3:0] outputs_closed,    // output states, 1 closed
	input  wire logic [15:0] adc1_raw,          // analog input one
	input  wire logic [15:0] adc2_raw,          // analog input two
	input  wire logic        jog_start,         // jog begins
	input  wire logic        fast_stop,         // fast halt
	input  wire logic        decel_stop,        // decelerating halt
	input  wire logic        motor_stopped      // motion reached zero
);
	typedef struct packed {
		logic [12:0] sync1;
		logic [12:0] sync2;
		logic        sens_prev;
		logic [15:0] analog_cmd;
		logic [31:0] enc;
		logic [31:0] traj;
		logic [31:0] rel;
		logic [31:0] rel_base;
		logic        rel_moving;
		logic [15:0] sensor_pos;
		logic  [7:0] cc;
		logic [15:0] io_word;
		logic [15:0] adc1;
		logic [15:0] adc2;
		logic        ans_valid;
		logic        ans_known;
		logic        load_ack;
		logic [31:0] ans_data;
	} drs_bank_t;

	drs_bank_t   st, next_st;
	logic  [2:0] vel_code;
	logic [12:0] pins;
	logic [15:0] io_next;
	logic  [7:0] in_open;
	logic        idx_open;

	if (IO_LAYOUT > 3) begin : bad_layout
		$error("IO_LAYOUT must be 0 to 3");
	end

	drs_vel_state #(.END_LEN(END_LEN)) u_vel (
		.mclk          (mclk),
		.sys_rst       (sys_rst),
		.ce            (ce),
		.jog_start     (jog_start),
		.fast_stop     (fast_stop),
		.decel_stop    (decel_stop),
		.motor_stopped (motor_stopped),
		.state_code    (vel_code)
	);

	// every pin goes through two flops before use
	assign pins = {sensor_pin, en_closed_pin, dir_closed_pin,
		step_closed_pin, index_closed_pin, inputs_closed_pin};
	assign in_open  = ~st.sync2[7:0];
	assign idx_open = ~st.sync2[8];

	function automatic logic [15:0] cmd_scale(input logic [15:0] raw,
		input logic [15:0] ofs);
		logic signed [16:0] sum;
		sum = $signed({raw[15], raw}) + $signed({ofs[15], ofs});
		if (BIPOLAR) begin
			if (sum > 17'(CMD_BIPOLAR_MAX)) return CMD_BIPOLAR_MAX;
			if (sum < 17'(CMD_BIPOLAR_MIN)) return CMD_BIPOLAR_MIN;
		end else begin
			// unipolar may leave 0..16383 through the offset
			if (sum > 17'(SHORT_MAX)) return SHORT_MAX;
			if (sum < 17'(SHORT_MIN)) return SHORT_MIN;
		end
		return sum[15:0];
	endfunction

	function automatic logic [15:0] adc_clamp(input logic [15:0] raw);
		return (raw > ADC_MAX) ? ADC_MAX : raw;
	endfunction

	always_comb begin
		io_next = 16'h0000;
		unique case (IO_LAYOUT)
			0: begin
				io_next[L0_IDX]        = idx_open;
				io_next[L0_IN +: 7]    = in_open[6:0];
				io_next[L0_OUT +: 3]   = outputs_closed[2:0];
			end
			1: begin
				io_next[L1_IN +: 8]    = in_open;
				io_next[L1_OUT +: 4]   = outputs_closed;
				io_next[L1_IDX]        = idx_open;
			end
			2: begin
				io_next[L2_IDX]        = idx_open;
				io_next[L2_STEP]       = ~st.sync2[9];
				io_next[L2_DIR]        = ~st.sync2[10];
				io_next[L2_EN]         = ~st.sync2[11];
				io_next[L2_OUT]        = outputs_closed[0];
			end
			default: begin
				io_next[L3_IN +: 4]    = in_open[3:0];
				io_next[L3_OUT +: 2]   = outputs_closed[1:0];
				io_next[L3_IDX]        = idx_open;
			end
		endcase
	end

	always_comb begin
		logic signed [31:0] a;
		logic signed [31:0] b;
		a = $signed(test_first);
		b = $signed(test_second);
		next_st = st;
		if (ce) begin
			next_st.ans_valid = 1'b0;
			next_st.load_ack  = 1'b0;
			next_st.sync1     = pins;
			next_st.sync2     = st.sync1;
			next_st.sens_prev = st.sync2[12];
			next_st.analog_cmd = cmd_scale(analog_cmd_raw,
				analog_offset_command);
			next_st.io_word   = io_next;
			next_st.adc1      = adc_clamp(adc1_raw);
			next_st.adc2      = adc_clamp(adc2_raw);

			if (encoder_preset_command) begin
				next_st.enc = encoder_preset_value;
			end else if (enc_step) begin
				next_st.enc = enc_dir ? st.enc - 32'h0000_0001
					: st.enc + 32'h0000_0001;
			end

			if (set_position) begin
				next_st.traj = set_position_value;
			end else if (traj_step) begin
				next_st.traj = traj_dir ? st.traj - 32'h0000_0001
					: st.traj + 32'h0000_0001;
			end

			if (rel_move_start) begin
				next_st.rel_base   = st.traj;
				next_st.rel_moving = 1'b1;
				if (!REL_AT_END) begin
					next_st.rel = 32'h0000_0000;
				end
			end else if (st.rel_moving) begin
				if (rel_move_done) begin
					next_st.rel_moving = 1'b0;
					next_st.rel = st.traj - st.rel_base;
				end else if (!REL_AT_END) begin
					next_st.rel = st.traj - st.rel_base;
				end
			end

			// rising edge of the synchronised sensor input
			if (sensor_move_active && st.sync2[12] && !st.sens_prev) begin
				next_st.sensor_pos = st.traj[15:0];
			end

			if (test_exec) begin
				next_st.cc          = CC_RESET;
				next_st.cc[CC_TRUE] = (a != 0);
				next_st.cc[CC_ZERO] = (a == 0);
				next_st.cc[CC_POS]  = (a > 0);
				next_st.cc[CC_NEG]  = (a < 0);
				next_st.cc[CC_GT]   = (a > b);
				next_st.cc[CC_LT]   = (a < b);
				next_st.cc[CC_EQ]   = (a == b);
				next_st.cc[CC_NE]   = (a != b);
			end

			// loads are acknowledged but never reach a register
			if (load_valid) begin
				next_st.load_ack = 1'b1;
			end

			if (query_valid) begin
				next_st.ans_valid = 1'b1;
				next_st.ans_known = 1'b1;
				unique case (query_index)
					IDX_ANALOG_CMD: next_st.ans_data = {16'h0000, st.analog_cmd};
					IDX_PROG_LINE:  next_st.ans_data =
						{26'h000_0000, program_line};
					IDX_CURRENT:    next_st.ans_data =
						{16'h0000, current_command};
					IDX_REL_DIST:   next_st.ans_data = st.rel;
					IDX_ENCODER:    next_st.ans_data = st.enc;
					IDX_FAULT:      next_st.ans_data = fault_in;
					IDX_SENSOR_POS: next_st.ans_data = {16'h0000, st.sensor_pos};
					IDX_COND_CODE:  next_st.ans_data = {24'h00_0000, st.cc};
					IDX_DRV_INPUTS: next_st.ans_data = {16'h0000, st.io_word};
					IDX_ANALOG_ONE: next_st.ans_data = {16'h0000, st.adc1};
					IDX_ANALOG_TWO: next_st.ans_data = {16'h0000, st.adc2};
					IDX_TRAJ_POS:   next_st.ans_data = st.traj;
					IDX_CTRL_MODE:  next_st.ans_data = {24'h00_0000, control_mode};
					IDX_VEL_STATE:  next_st.ans_data = {29'h0000_0000, vel_code};
					IDX_RUN_PHASE:  next_st.ans_data = {28'h000_0000, run_phase};
					default: begin
						next_st.ans_known = 1'b0;
						next_st.ans_data  = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign answer_valid = st.ans_valid;
	assign answer_known = st.ans_known;
	assign answer_data  = st.ans_data;
	assign load_ack     = st.load_ack;

	sequence sensor_edge_s;
		ce && sensor_move_active && st.sync2[12] && !st.sens_prev;
	endsequence

	sequence query_s;
		ce && query_valid;
	endsequence

	cmd_range_a: assert property (@(posedge mclk) disable iff (sys_rst)
		BIPOLAR |-> ($signed(st.analog_cmd) <= CMD_BIPOLAR_MAX
		&& $signed(st.analog_cmd) >= CMD_BIPOLAR_MIN))
		else $error("analog command outside bipolar span");

	cmd_offset_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(ce && analog_offset_command == 16'h0000 && !analog_cmd_raw[15]
		&& analog_cmd_raw <= 16'h3FFF)
		|=> st.analog_cmd == $past(analog_cmd_raw))
		else $error("analog command not raw plus offset");

	line_short_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(query_s and (query_index == IDX_PROG_LINE))
		|=> answer_data[31:6] == 26'h000_0000
		&& answer_data[5:0] == $past(program_line))
		else $error("program line answer malformed");

	rel_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(REL_AT_END && ce && !rel_move_done && !rel_move_start)
		|=> $stable(st.rel))
		else $error("relative distance changed before move end");

	rel_track_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(!REL_AT_END && ce && st.rel_moving && !rel_move_start)
		|=> st.rel == $past(st.traj) - $past(st.rel_base))
		else $error("relative distance not tracking");

	preset_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(ce && encoder_preset_command && encoder_preset_value == 32'h0000_0000)
		|=> st.enc == 32'h0000_0000)
		else $error("encoder not cleared by zero preset");

	sensor_capture_a: assert property (@(posedge mclk) disable iff (sys_rst)
		sensor_edge_s |=> st.sensor_pos == $past(st.traj[15:0]))
		else $error("sensor position not captured");

	power_zero_a: assert property (@(posedge mclk)
		$fell(sys_rst) |-> st.traj == POS_RESET && st.enc == POS_RESET)
		else $error("position not zero after reset");

	cond_flags_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(ce && test_exec) |=> st.cc[CC_TRUE] == ($past(test_first) != 0)
		&& st.cc[CC_NE] == ($past(test_first) != $past(test_second))
		&& st.cc[CC_GT] == ($signed($past(test_first))
		> $signed($past(test_second))))
		else $error("condition flags wrong after test");

	cond_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!(ce && test_exec) |=> $stable(st.cc))
		else $error("condition code changed without test");

	index_bit_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(ce && IO_LAYOUT == 0) |=> st.io_word[L0_IDX] == !$past(st.sync2[8])
		&& st.io_word[15:11] == 5'h00)
		else $error("input word layout wrong");

	unused_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
		((IO_LAYOUT != 2) || (st.io_word[15:9] == 7'h00
		&& st.io_word[7:4] == 4'h0))
		&& ((IO_LAYOUT != 1) || st.io_word[15:13] == 3'h0))
		else $error("unused input word bits set");

	adc_range_a: assert property (@(posedge mclk) disable iff (sys_rst)
		st.adc1 <= ADC_MAX && st.adc2 <= ADC_MAX)
		else $error("analog input above full scale");

	query_answer_a: assert property (@(posedge mclk) disable iff (sys_rst)
		query_s |=> answer_valid ##1 (!answer_valid || $past(ce && query_valid)))
		else $error("query answer timing wrong");

	load_ignored_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(ce && load_valid && !encoder_preset_command && !enc_step)
		|=> load_ack && $stable(st.enc))
		else $error("load attempt had an effect");

endmodule // drs_status_bank
`default_nettype wire

// [logic/drs_pkg.sv]
// constants and types shared by the read-only status register bank
package drs_pkg;

	// timing
	localparam int unsigned MCLK_HZ        = 40_000_000;
	localparam int unsigned END_TIME_US    = 62;
	localparam int unsigned END_CYCLES     = (MCLK_HZ / 1_000_000) * END_TIME_US;

	// register indices as used by the register load query (decimal 49 - 63)
	localparam logic [7:0] IDX_ANALOG_CMD  = 8'h31;
	localparam logic [7:0] IDX_PROG_LINE   = 8'h32;
	localparam logic [7:0] IDX_CURRENT     = 8'h33;
	localparam logic [7:0] IDX_REL_DIST    = 8'h34;
	localparam logic [7:0] IDX_ENCODER     = 8'h35;
	localparam logic [7:0] IDX_FAULT       = 8'h36;
	localparam logic [7:0] IDX_SENSOR_POS  = 8'h37;
	localparam logic [7:0] IDX_COND_CODE   = 8'h38;
	localparam logic [7:0] IDX_DRV_INPUTS  = 8'h39;
	localparam logic [7:0] IDX_ANALOG_ONE  = 8'h3A;
	localparam logic [7:0] IDX_ANALOG_TWO  = 8'h3B;
	localparam logic [7:0] IDX_TRAJ_POS    = 8'h3C;
	localparam logic [7:0] IDX_CTRL_MODE   = 8'h3D;
	localparam logic [7:0] IDX_VEL_STATE   = 8'h3E;
	localparam logic [7:0] IDX_RUN_PHASE   = 8'h3F;

	// analog scaling
	localparam logic signed [15:0] CMD_BIPOLAR_MAX = 16'sh7FF8;
	localparam logic signed [15:0] CMD_BIPOLAR_MIN = -16'sh7FF8;
	localparam logic signed [15:0] CMD_UNIPOLAR_FS = 16'sh3FFF;
	localparam logic signed [15:0] SHORT_MAX       = 16'sh7FFF;
	localparam logic signed [15:0] SHORT_MIN       = -16'sh8000;
	localparam logic [15:0]        ADC_MAX         = 16'h7FF8;
	localparam logic [15:0]        ADC_ZERO_VOLT   = 16'h3FFF;

	// condition code bit positions
	localparam int unsigned CC_TRUE = 0;
	localparam int unsigned CC_ZERO = 1;
	localparam int unsigned CC_POS  = 2;
	localparam int unsigned CC_NEG  = 3;
	localparam int unsigned CC_GT   = 4;
	localparam int unsigned CC_LT   = 5;
	localparam int unsigned CC_EQ   = 6;
	localparam int unsigned CC_NE   = 7;

	// input word layouts
	localparam int unsigned L0_IDX  = 0;
	localparam int unsigned L0_IN   = 1;
	localparam int unsigned L0_OUT  = 8;
	localparam int unsigned L1_IN   = 0;
	localparam int unsigned L1_OUT  = 8;
	localparam int unsigned L1_IDX  = 12;
	localparam int unsigned L2_IDX  = 0;
	localparam int unsigned L2_STEP = 1;
	localparam int unsigned L2_DIR  = 2;
	localparam int unsigned L2_EN   = 3;
	localparam int unsigned L2_OUT  = 8;
	localparam int unsigned L3_IN   = 0;
	localparam int unsigned L3_OUT  = 8;
	localparam int unsigned L3_IDX  = 14;

	// reset values
	localparam logic [31:0] POS_RESET = 32'h0000_0000;
	localparam logic [7:0]  CC_RESET  = 8'h00;

	typedef enum logic [2:0] {
		VS_WAITING  = 3'b000,
		VS_RUNNING  = 3'b001,
		VS_FAST     = 3'b010,
		VS_STOPPING = 3'b011,
		VS_ENDING   = 3'b100
	} drs_vel_t;

endpackage

// [logic/drs_vel_state.sv]
// velocity move state tracker with timed end-of-move cleanup
`timescale 1ns/1ps
`default_nettype none
module drs_vel_state import drs_pkg::*; #(
	parameter int unsigned END_LEN = END_CYCLES
) (
	input  wire logic       mclk,          // 40 MHz clock
	input  wire logic       sys_rst,       // async reset, high
	input  wire logic       ce,            // clock enable
	input  wire logic       jog_start,     // jog begins
	input  wire logic       fast_stop,     // halt without decel
	input  wire logic       decel_stop,    // decelerating halt
	input  wire logic       motor_stopped, // motion reached zero
	output logic      [2:0] state_code     // velocity state number
);
	typedef struct packed {
		drs_vel_t    state;
		logic [11:0] cnt;
	} drs_vel_st_t;

	drs_vel_st_t st, next_st;

	if (END_LEN < 1 || END_LEN > 4096) begin : bad_cfg
		$error("END_LEN outside counter range");
	end

	always_comb begin
		next_st = st;
		if (ce) begin
			unique case (st.state)
				VS_WAITING: if (jog_start) begin
					next_st.state = VS_RUNNING;
				end
				VS_RUNNING: if (fast_stop) begin
					next_st.state = VS_FAST;
				end else if (decel_stop) begin
					next_st.state = VS_STOPPING;
				end
				VS_FAST, VS_STOPPING: if (motor_stopped) begin
					next_st.state = VS_ENDING;
					next_st.cnt   = '0;
				end
				VS_ENDING: begin
					// cleanup lasts one pwm period, then back to waiting
					if (st.cnt == 12'(END_LEN - 1)) begin
						next_st.state = VS_WAITING;
					end else begin
						next_st.cnt = st.cnt + 12'h001;
					end
				end
				default: next_st.state = VS_WAITING;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '{state: VS_WAITING, cnt: 12'h000};
		end else begin
			st <= next_st;
		end
	end

	assign state_code = st.state;

	sequence end_entry_s;
		ce && (st.state != VS_ENDING) && (next_st.state == VS_ENDING);
	endsequence

	state_codes_a: assert property (
		@(posedge mclk) disable iff (sys_rst) state_code <= 3'h4)
		else $error("velocity state code out of range");

	end_start_a: assert property (
		@(posedge mclk) disable iff (sys_rst) end_entry_s |=> st.cnt == 12'h000)
		else $error("cleanup count not restarted");

	end_length_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(st.state == VS_ENDING && ce && st.cnt == 12'(END_LEN - 1))
		|=> st.state == VS_WAITING && $past(st.cnt) == 12'(END_LEN - 1))
		else $error("cleanup did not end after one pwm period");

	end_hold_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(st.state == VS_ENDING && st.cnt < 12'(END_LEN - 1))
		|=> st.state == VS_ENDING)
		else $error("cleanup ended early");

endmodule // drs_vel_state
`default_nettype wire

// [bench/drs_host.sv]
// host side of the query link: register queries, load attempts, presets
`timescale 1ns/1ps
`default_nettype none
module drs_host (
	input  wire logic        mclk,                   // bank clock
	output logic             query_valid,            // query pulse
	output logic       [7:0] query_index,            // register number
	output logic             load_valid,             // load attempt
	output logic       [7:0] load_index,             // load target
	output logic             encoder_preset_command, // preset strobe
	output logic      [31:0] encoder_preset_value,   // preset value
	input  wire logic        answer_valid,           // answer pulse
	input  wire logic        answer_known,           // index mapped
	input  wire logic [31:0] answer_data,            // answer value
	input  wire logic        load_ack                // load taken
);
	logic got_valid, got_known, ack;
	initial begin
		{query_valid, load_valid, encoder_preset_command} = '0;
		{query_index, load_index, encoder_preset_value} = '0;
	end
	// released fields show the inverse so stale values are never trusted
	task automatic ask(input logic [7:0] idx, output logic [31:0] d);
		@(negedge mclk);
		query_valid = 1'b1;
		query_index = idx;
		@(negedge mclk);
		// the answer pulse stands only in the cycle after the taking edge
		d = answer_data;
		got_valid = answer_valid;
		got_known = answer_known;
		query_valid = 1'b0;
		query_index = ~idx;
	endtask
	task automatic load(input logic [7:0] idx);
		@(negedge mclk);
		load_valid = 1'b1;
		load_index = idx;
		@(negedge mclk);
		ack = load_ack;
		load_valid = 1'b0;
		load_index = ~idx;
	endtask
	task automatic preset();
		@(negedge mclk);
		encoder_preset_command = 1'b1;
		encoder_preset_value = 32'h0000_0000;
		@(negedge mclk);
		encoder_preset_command = 1'b0;
		encoder_preset_value = 32'hFFFF_FFFF;
	endtask
endmodule // drs_host
`default_nettype wire

// [bench/drive_readonly_status_registers_tb.sv]
// self-checking bench for the read-only status register bank
`timescale 1ns/1ps
`default_nettype none
module drive_readonly_status_registers_tb import drs_pkg::*;;
	localparam int unsigned EL = 4; // short cleanup keeps the run brief
	logic        mclk, sys_rst, ce, query_valid, load_valid, answer_valid;
	logic        answer_known, load_ack, traj_step, traj_dir, enc_step;
	logic        enc_dir, encoder_preset_command, set_position, test_exec;
	logic        rel_move_start, rel_move_done, sensor_move_active;
	logic        sensor_pin, index_closed_pin, step_closed_pin;
	logic        dir_closed_pin, en_closed_pin, jog_start, fast_stop;
	logic        decel_stop, motor_stopped;
	logic  [3:0] run_phase, outputs_closed;
	logic  [5:0] program_line;
	logic  [7:0] query_index, load_index, control_mode, inputs_closed_pin;
	logic [15:0] analog_cmd_raw, analog_offset_command, current_command;
	logic [15:0] adc1_raw, adc2_raw;
	logic [31:0] answer_data, fault_in, encoder_preset_value, d, v;
	logic [31:0] set_position_value, test_first, test_second;
	int          fails, num_checks, n, cyc = 0;

	drs_status_bank #(.IO_LAYOUT(1), .END_LEN(EL)) dut_u (.*);
	drs_host host_u (.*);

	initial mclk = 1'b0;
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic q(input logic [7:0] idx, input logic [31:0] exp);
		host_u.ask(idx, d);
		chk({30'd0, host_u.got_valid, host_u.got_known}, 32'd3);
		chk(d, exp);
		@(negedge mclk);
	endtask
	task automatic pulse(ref logic s);
		@(negedge mclk);
		s = 1'b1;
		@(negedge mclk);
		s = 1'b0;
	endtask
	function automatic logic [31:0] ccx(input int a, input int b);
		ccx = '0;
		ccx[CC_TRUE] = a != 0;
		ccx[CC_ZERO] = a == 0;
		ccx[CC_POS] = a > 0;
		ccx[CC_NEG] = a < 0;
		ccx[CC_GT] = a > b;
		ccx[CC_LT] = a < b;
		ccx[CC_EQ] = a == b;
		ccx[CC_NE] = a != b;
	endfunction
	task automatic end_of_test();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		void'($urandom(70));
		{fails, num_checks} = '0;
		{traj_step, traj_dir, enc_step, enc_dir, set_position, test_exec,
			rel_move_start, rel_move_done, sensor_move_active, sensor_pin,
			jog_start, fast_stop, decel_stop, motor_stopped, index_closed_pin,
			step_closed_pin, dir_closed_pin, en_closed_pin} = '0;
		{run_phase, outputs_closed, program_line, control_mode,
			inputs_closed_pin, analog_cmd_raw, analog_offset_command,
			current_command, adc1_raw, adc2_raw, fault_in,
			set_position_value, test_first, test_second} = '0;
		ce = 1'b1;
		sys_rst = 1'b1;
		repeat (8) @(negedge mclk);
		sys_rst = 1'b0;
		q(IDX_ENCODER, 32'h0);
		q(IDX_TRAJ_POS, 32'h0);
		$display("reset test done");
		program_line = 6'($urandom_range(62, 1));
		current_command = 16'($urandom);
		fault_in = $urandom;
		control_mode = 8'($urandom);
		run_phase = 4'($urandom);
		q(IDX_PROG_LINE, {26'd0, program_line});
		q(IDX_CURRENT, {16'd0, current_command});
		q(IDX_FAULT, fault_in);
		q(IDX_CTRL_MODE, {24'd0, control_mode});
		q(IDX_RUN_PHASE, {28'd0, run_phase});
		$display("live test done");
		n = $urandom_range(20, 4);
		repeat (n) pulse(enc_step);
		enc_dir = 1'b1;
		repeat (3) pulse(enc_step);
		ce = 1'b0; // a frozen enable must swallow this step
		pulse(enc_step);
		ce = 1'b1;
		q(IDX_ENCODER, 32'(n - 3));
		host_u.preset();
		q(IDX_ENCODER, 32'h0);
		$display("encoder test done");
		v = $urandom;
		set_position_value = v;
		pulse(set_position);
		pulse(rel_move_start);
		repeat (n) pulse(traj_step);
		q(IDX_REL_DIST, 32'(n));
		q(IDX_TRAJ_POS, v + 32'(n));
		pulse(rel_move_done);
		sensor_move_active = 1'b1;
		sensor_pin = 1'b1;
		repeat (3) @(negedge mclk); // two sync flops, then the capture edge
		q(IDX_SENSOR_POS, {16'd0, 16'(v + 32'(n))});
		sensor_move_active = 1'b0;
		$display("motion test done");
		for (int i = 0; i < 8; i++) begin
			test_first = i == 0 ? 32'd5 : i == 1 ? 32'd0
				: 32'($urandom_range(8)) - 32'd4;
			test_second = i < 2 ? 32'(3 * (1 - i))
				: 32'($urandom_range(8)) - 32'd4;
			pulse(test_exec);
			q(IDX_COND_CODE, ccx(test_first, test_second));
		end
		$display("condition test done");
		for (int i = 0; i < 4; i++) begin
			{inputs_closed_pin, index_closed_pin, outputs_closed} = 13'($urandom);
			{step_closed_pin, dir_closed_pin, en_closed_pin} = 3'($urandom);
			repeat (5) @(negedge mclk);
			q(IDX_DRV_INPUTS, {19'd0, ~index_closed_pin, outputs_closed,
				~inputs_closed_pin});
		end
		adc1_raw = 16'($urandom);
		adc2_raw = 16'hFFFF;
		{analog_cmd_raw, analog_offset_command} = {16'h7530, 16'h1388};
		q(IDX_ANALOG_ONE, {16'd0, adc1_raw > ADC_MAX ? ADC_MAX : adc1_raw});
		q(IDX_ANALOG_TWO, 32'h0000_7FF8);
		q(IDX_ANALOG_CMD, 32'h0000_7FF8);
		{analog_cmd_raw, analog_offset_command} = {16'h8AD0, 16'hEC78};
		q(IDX_ANALOG_CMD, 32'h0000_8008);
		{analog_cmd_raw, analog_offset_command} = {16'h0064, 16'h0017};
		q(IDX_ANALOG_CMD, 32'h0000_007B);
		$display("analog test done");
		for (int k = 0; k < 2; k++) begin
			pulse(jog_start);
			q(IDX_VEL_STATE, 32'd1);
			if (k == 0) begin
				pulse(fast_stop);
			end else begin
				pulse(decel_stop);
			end
			q(IDX_VEL_STATE, 32'(2 + k));
			pulse(motor_stopped);
			q(IDX_VEL_STATE, 32'd4);
			repeat (EL) @(negedge mclk);
			q(IDX_VEL_STATE, 32'd0);
		end
		$display("velocity test done");
		sys_rst = 1'b1;
		@(negedge mclk);
		sys_rst = 1'b0;
		q(IDX_TRAJ_POS, 32'h0);
		q(IDX_VEL_STATE, 32'd0);
		$display("second reset test done");
		host_u.load(IDX_ANALOG_CMD);
		chk({31'd0, host_u.ack}, 32'd1);
		q(IDX_ANALOG_CMD, 32'h0000_007B);
		host_u.ask(8'h40, d);
		chk({30'd0, host_u.got_valid, host_u.got_known}, 32'd2);
		chk(d, 32'h0);
		$display("load test done");
		end_of_test();
	end
endmodule // drive_readonly_status_registers_tb
`default_nettype wire
